// ==== mcu_test_xor_and_stack_ext_decode_bench.sv ====
`timescale 1ns/1ps
`include "mxd_map.svh"
// ***
// Bench
// ***
module mcu_test_xor_and_stack_ext_decode_bench;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp;
   logic [31:0] hrdata, rd;
   logic [15:0] instr_word;
   logic [20:0] prog_addr;
   int failures = 0;
   int comparisons = 0;
   always #5 clk = ~clk;
   mxd_core mxd_core_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .instr_word(instr_word), .prog_addr(prog_addr), .q_phase());
   mxd_prog_mem mxd_prog_mem_inst (.prog_addr(prog_addr), .instr_word(instr_word));
   task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      chk(rd & mask, exp);
   endtask
   // Registers other than CTRL, STAT and DBG_ADDR only take writes while stopped, so every program runs between two stops.
   task run(input logic [31:0] ctrl, input logic [20:0] pc);
      ahb(1'b1, `MXD_ADDR_PC, {11'h0, pc});
      ahb(1'b1, `MXD_ADDR_CTRL, ctrl);
      repeat (48) @(posedge clk);
      ahb(1'b1, `MXD_ADDR_CTRL, ctrl & 32'hFFFFFFFE);
   endtask
   task test_xor_skip;
      ahb(1'b1, `MXD_ADDR_ACC, 32'hB5);
      ahb(1'b1, `MXD_ADDR_DBG_ADDR, 32'h10);
      ahb(1'b1, `MXD_ADDR_DBG_DATA, 32'h00);
      ahb(1'b1, `MXD_ADDR_DBG_ADDR, 32'h11);
      ahb(1'b1, `MXD_ADDR_DBG_DATA, 32'h05);
      run(32'h1, 21'h0);
      rdchk(`MXD_ADDR_ACC, 32'hFF, 32'h00);
      rdchk(`MXD_ADDR_STAT, 32'h7, 32'h1);
      rdchk(`MXD_ADDR_DBG_DATA, 32'hFF, 32'h1E);
   endtask
   task test_ext_on;
      ahb(1'b1, `MXD_ADDR_PTR2, 32'h100);
      ahb(1'b1, `MXD_ADDR_PTR0, 32'h3FF);
      run(32'h3, 21'h40);
      rdchk(`MXD_ADDR_PTR2, 32'hFFF, 32'h0FF);
      rdchk(`MXD_ADDR_PTR0, 32'hFFF, 32'h41D);
      ahb(1'b1, `MXD_ADDR_DBG_ADDR, 32'h100);
      rdchk(`MXD_ADDR_DBG_DATA, 32'hFF, 32'h42);
      rdchk(`MXD_ADDR_STAT, 32'h7, 32'h1);
   endtask
   task test_ext_off;
      run(32'h1, 21'h60);
      rdchk(`MXD_ADDR_STAT, 32'h4, 32'h4);
      rdchk(`MXD_ADDR_PTR2, 32'hFFF, 32'h0FF);
   endtask
   task test_ext_flow;
      ahb(1'b1, `MXD_ADDR_PTR2, 32'hF80);
      ahb(1'b1, `MXD_ADDR_BANK, 32'h2);
      ahb(1'b1, `MXD_ADDR_ACC, 32'h2C);
      ahb(1'b1, `MXD_ADDR_DBG_ADDR, 32'h240);
      ahb(1'b1, `MXD_ADDR_DBG_DATA, 32'h00);
      ahb(1'b1, `MXD_ADDR_DBG_ADDR, 32'hF81);
      ahb(1'b1, `MXD_ADDR_DBG_DATA, 32'h0F);
      run(32'h3, 21'h18);
      rdchk(`MXD_ADDR_ACC, 32'hFF, 32'h2C);
      rdchk(`MXD_ADDR_STAT, 32'h3, 32'h0);
      rdchk(`MXD_ADDR_DBG_DATA, 32'hFF, 32'h00);
      ahb(1'b1, `MXD_ADDR_DBG_ADDR, 32'hF82);
      rdchk(`MXD_ADDR_DBG_DATA, 32'hFF, 32'h23);
      rdchk(`MXD_ADDR_PTR2, 32'hFFF, 32'hF85);
      rdchk(`MXD_ADDR_PC, 32'h1FFFFF, 32'h1A);
      rdchk(`MXD_ADDR_STACK, 32'hFFFFFFFF, 32'h0);
      ahb(1'b1, `MXD_ADDR_ACC, 32'h3E);
      run(32'h3, 21'h1A);
      rdchk(`MXD_ADDR_PTR2, 32'hFFF, 32'hF82);
      rdchk(`MXD_ADDR_STACK, 32'hFFFFFFFF, 32'h0);
   endtask
   task end_of_test;
      $display("Comparisons %0d, failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      rdchk(`MXD_ADDR_CTRL, 32'h3, 32'h0);
      test_xor_skip;
      test_ext_on;
      test_ext_off;
      test_ext_flow;
      end_of_test;
   end
   // The whole run needs well under a thousand cycles.
   initial begin
      repeat (4000) @(posedge clk);
      failures++;
      end_of_test;
   end
endmodule

// ==== mxd_core.sv ====
`timescale 1ns/1ps
`include "mxd_map.svh"

// Summary of operation
// - Test-and-skip on zero discards the fetched next word, two cycles.
// - Skipping over a two-word instruction flushes both words, three cycles.
// - Access bit clear selects the Access Bank for the register operand.
// - Access bit set forms the address from bank select and operand.
// - Extended set, access clear, operand up to 95 uses indexed literal offset.
// - XOR literal into accumulator, update N and Z, one cycle.
// - XOR accumulator with register, result to accumulator or register, N and Z.
// - Extended set and indexed offset mode are off until the config bit is set.
// - Standard set plus eight extended opcodes; extended ones leave flags alone.
// - Add or subtract six-bit literal on the selected pointer in one cycle.
// - Pointer-three add form adds to stack pointer then returns, two cycles.
// - Pointer-three subtract form subtracts from stack pointer then returns.
// - Push literal stores at stack pointer address then decrements it.
// - Call via accumulator is one word and two cycles.
// - Call pushes PC+2, target from accumulator and latches, second cycle idle.
// - Indexed-to-file move reads stack pointer plus offset; indirect source reads zero.
// - Indexed-to-indexed move copies between two stack pointer offsets, two cycles.
// - Pointer add is unsigned and carries into the upper pointer bits.
module mxd_core
   import mxd_pkg::*;
#(
   parameter int STACK_DEPTH = 31,
   parameter int DMEM_WORDS = 4096
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [15:0] instr_word,
   output logic [20:0] prog_addr,
   output logic [1:0] q_phase
);

   localparam int SPW = $clog2(STACK_DEPTH + 1);

   // ****************************************************************
   // State
   // ****************************************************************
   logic run;
   logic extended_set_config_bit;
   logic [7:0] working_register;
   logic flag_z;
   logic flag_n;
   logic undec;
   logic [3:0] bank_select_register;
   logic [7:0] program_counter_high_latch;
   logic [4:0] program_counter_upper_latch;
   logic [11:0] file_select_pointer [3];
   logic [20:0] stk [STACK_DEPTH];
   logic [SPW-1:0] sp;
   logic [7:0] dmem [DMEM_WORDS];
   logic [11:0] dbg_addr;
   logic [15:0] ir;
   logic [15:0] ir2;
   logic skip_two;
   logic [7:0] opnd;
   logic [7:0] res;
   mxd_state_t st;
   mxd_state_t next_st;
   mxd_bus_t dphase;
   mxd_dec_t dec;
   logic core_step;
   logic retire;
   logic [11:0] ea;
   logic [11:0] src_addr;
   logic [11:0] dst_addr;
   logic [11:0] stack_pointer_register;
   logic [20:0] top_of_return_stack;
   logic ap_ok;
   logic [31:0] rd_val;
   logic sw_ok;
   logic dm_we;
   logic [11:0] dm_wa;
   logic [7:0] dm_wd;

   assign core_step = clk_en & run;
   assign retire = core_step && (q_phase == `MXD_Q4);
   assign stack_pointer_register = file_select_pointer[2];
   assign top_of_return_stack = (sp == '0) ? 21'h0 : stk[sp - SPW'(1)];

   function automatic logic is_two_word(input logic [15:0] w, input logic ext);
      is_two_word = (w[15:12] == `MXD_OP_MOVFF) || (w[15:9] == `MXD_OP_CALL) ||
         (w[15:8] == `MXD_OP_LDPTR) || (w[15:8] == `MXD_OP_GOTO) ||
         (ext && (w[15:8] == `MXD_OP_MOVS));
   endfunction

   function automatic logic is_indirect(input logic [11:0] a);
      is_indirect = (a[11:8] == 4'hF) && (a[7:3] >= `MXD_IND_LO) &&
         (a[7:3] <= `MXD_IND_HI) && (a[2:0] >= `MXD_IND_MIN);
   endfunction

   // ****************************************************************
   // Decode and address formation
   // ****************************************************************
   always_comb begin
      dec = '0;
      dec.test_reg_skip_zero = ir[15:9] == `MXD_OP_TST;
      dec.xor_literal_into_acc = ir[15:8] == `MXD_OP_XOR_LITERAL_INTO_ACC;
      dec.xor_acc_with_reg = ir[15:10] == `MXD_OP_XOR_ACC_WITH_REG;
      dec.ext_seen = (ir[15:8] == `MXD_OP_ADDP) || (ir[15:8] == `MXD_OP_SUBP) ||
         (ir[15:8] == `MXD_OP_PUSH_LITERAL) || (ir[15:8] == `MXD_OP_MOVS) ||
         (ir == `MXD_OP_CALL_VIA_ACC);
      // Extended opcodes fall through as no-ops unless the set is enabled.
      if (extended_set_config_bit) begin
         dec.add_literal_to_pointer = (ir[15:8] == `MXD_OP_ADDP) &&
            (ir[7:6] != `MXD_STACK_SEL);
         dec.sub_literal_from_pointer = (ir[15:8] == `MXD_OP_SUBP) &&
            (ir[7:6] != `MXD_STACK_SEL);
         dec.add_stack_ptr_and_return = (ir[15:8] == `MXD_OP_ADDP) &&
            (ir[7:6] == `MXD_STACK_SEL);
         dec.sub_stack_ptr_and_return = (ir[15:8] == `MXD_OP_SUBP) &&
            (ir[7:6] == `MXD_STACK_SEL);
         dec.push_literal = ir[15:8] == `MXD_OP_PUSH_LITERAL;
         dec.call_via_acc = ir == `MXD_OP_CALL_VIA_ACC;
         dec.move_indexed_to_file = (ir[15:8] == `MXD_OP_MOVS) && !ir[7];
         dec.move_indexed_to_indexed = (ir[15:8] == `MXD_OP_MOVS) && ir[7];
      end
   end

   always_comb begin
      if (ir[8]) begin
         ea = {bank_select_register, ir[7:0]};
      end else if (extended_set_config_bit && (ir[7:0] <= `MXD_ILO_MAX)) begin
         ea = stack_pointer_register + {4'h0, ir[7:0]};
      end else if (ir[7:0] < `MXD_ACC_SPLIT) begin
         ea = {4'h0, ir[7:0]};
      end else begin
         ea = {4'hF, ir[7:0]};
      end
   end

   assign src_addr = stack_pointer_register + {5'h00, ir[6:0]};
   assign dst_addr = dec.move_indexed_to_indexed ?
      stack_pointer_register + {5'h00, ir2[6:0]} : ir2[11:0];

   // ****************************************************************
   // Cycle sequencing
   // ****************************************************************
   always_comb begin
      unique case (st)
         MXD_EXEC: begin
            if (dec.test_reg_skip_zero && (opnd == 8'h00)) begin
               next_st = MXD_SKIP;
            end else if (dec.add_stack_ptr_and_return || dec.sub_stack_ptr_and_return ||
                  dec.call_via_acc) begin
               next_st = MXD_BUBBLE;
            end else if (dec.move_indexed_to_file || dec.move_indexed_to_indexed) begin
               next_st = MXD_WORD2;
            end else begin
               next_st = MXD_EXEC;
            end
         end
         MXD_SKIP: begin
            next_st = skip_two ? MXD_SKIP2 : MXD_EXEC;
         end
         default: begin
            next_st = MXD_EXEC;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q_phase <= `MXD_Q1;
         st <= MXD_EXEC;
      end else if (core_step) begin
         q_phase <= q_phase + 2'h1;
         if (q_phase == `MXD_Q4) begin
            st <= next_st;
         end
      end else if (clk_en && sw_ok && (dphase.addr == `MXD_ADDR_PC)) begin
         // A stop may fall mid-cycle; a new program counter starts a clean cycle at it.
         q_phase <= `MXD_Q1;
         st <= MXD_EXEC;
      end
   end

   // Q1 fetch latch; in a skip cycle only the two-word test is kept.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ir <= 16'h0000;
         ir2 <= 16'h0000;
         skip_two <= 1'b0;
      end else if (core_step && (q_phase == `MXD_Q1)) begin
         if (st == MXD_EXEC) begin
            ir <= instr_word;
         end
         if (st == MXD_WORD2) begin
            ir2 <= instr_word;
         end
         if (st == MXD_SKIP) begin
            skip_two <= is_two_word(instr_word, extended_set_config_bit);
         end
      end
   end

   // Q2 reads the operand, Q3 processes it.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         opnd <= 8'h00;
         res <= 8'h00;
      end else if (core_step && (st == MXD_EXEC)) begin
         if (q_phase == `MXD_Q2) begin
            if (dec.move_indexed_to_file || dec.move_indexed_to_indexed) begin
               opnd <= is_indirect(src_addr) ? 8'h00 : dmem[src_addr];
            end else begin
               opnd <= dmem[ea];
            end
         end
         if (q_phase == `MXD_Q3) begin
            res <= working_register ^
               (dec.xor_literal_into_acc ? ir[7:0] : opnd);
         end
      end
   end

   // ****************************************************************
   // Write-back at Q4
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         working_register <= 8'h00;
         flag_z <= 1'b0;
         flag_n <= 1'b0;
      end else if (clk_en) begin
         if (retire && (st == MXD_EXEC) &&
               (dec.xor_literal_into_acc || dec.xor_acc_with_reg)) begin
            if (dec.xor_literal_into_acc || !ir[9]) begin
               working_register <= res;
            end
            flag_z <= res == 8'h00;
            flag_n <= res[7];
         end else if (sw_ok && (dphase.addr == `MXD_ADDR_ACC)) begin
            working_register <= hwdata[7:0];
         end
      end
   end

   always_comb begin
      dm_we = 1'b0;
      dm_wa = dst_addr;
      dm_wd = opnd;
      if (retire && (st == MXD_EXEC) && dec.xor_acc_with_reg && ir[9]) begin
         dm_we = 1'b1;
         dm_wa = ea;
         dm_wd = res;
      end else if (retire && (st == MXD_EXEC) && dec.push_literal) begin
         dm_we = 1'b1;
         dm_wa = stack_pointer_register;
         dm_wd = ir[7:0];
      end else if (retire && (st == MXD_WORD2)) begin
         // Writes to the program counter low byte or return stack are dropped.
         dm_we = (dst_addr != `MXD_DST_PCLOW) && (dst_addr != `MXD_DST_RSL) &&
            (dst_addr != `MXD_DST_RSH) && (dst_addr != `MXD_DST_RSU);
      end else if (sw_ok && (dphase.addr == `MXD_ADDR_DBG_DATA)) begin
         dm_we = 1'b1;
         dm_wa = dbg_addr;
         dm_wd = hwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (clk_en && dm_we) begin
         dmem[dm_wa] <= dm_wd;
      end
   end

   // Pointer adds are unsigned over all twelve bits so a carry reaches the top.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 3; i++) begin
            file_select_pointer[i] <= 12'h000;
         end
      end else if (clk_en) begin
         if (retire && (st == MXD_EXEC)) begin
            if (dec.add_literal_to_pointer || dec.add_stack_ptr_and_return) begin
               file_select_pointer[ir[7:6] == `MXD_STACK_SEL ? 2'h2 : ir[7:6]] <=
                  file_select_pointer[ir[7:6] == `MXD_STACK_SEL ? 2'h2 : ir[7:6]] +
                  {6'h00, ir[5:0]};
            end else if (dec.sub_literal_from_pointer || dec.sub_stack_ptr_and_return) begin
               file_select_pointer[ir[7:6] == `MXD_STACK_SEL ? 2'h2 : ir[7:6]] <=
                  file_select_pointer[ir[7:6] == `MXD_STACK_SEL ? 2'h2 : ir[7:6]] -
                  {6'h00, ir[5:0]};
            end else if (dec.push_literal) begin
               file_select_pointer[2] <= stack_pointer_register - 12'h001;
            end
         end else if (sw_ok) begin
            for (int i = 0; i < 3; i++) begin
               if (dphase.addr == `MXD_ADDR_PTR0 + 12'(4 * i)) begin
                  file_select_pointer[i] <= hwdata[11:0];
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prog_addr <= `MXD_PC_RESET;
         sp <= '0;
      end else if (clk_en) begin
         if (retire) begin
            if ((st == MXD_EXEC) && (dec.add_stack_ptr_and_return ||
                  dec.sub_stack_ptr_and_return)) begin
               prog_addr <= top_of_return_stack;
               sp <= sp - SPW'(1);
            end else if ((st == MXD_EXEC) && dec.call_via_acc) begin
               stk[sp] <= prog_addr + `MXD_PC_STEP;
               sp <= sp + SPW'(1);
               prog_addr <= {program_counter_upper_latch, program_counter_high_latch,
                  working_register};
            end else if (st != MXD_BUBBLE) begin
               // Skip cycles step past the discarded word; the bubble holds.
               prog_addr <= prog_addr + `MXD_PC_STEP;
            end
         end else if (sw_ok && (dphase.addr == `MXD_ADDR_PC)) begin
            prog_addr <= hwdata[20:0];
         end
      end
   end

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   assign ap_ok = hsel && htrans[1] && hready;
   assign sw_ok = dphase.wr && !run;

   always_comb begin
      unique case (haddr[11:0])
         `MXD_ADDR_CTRL: rd_val = {30'h0, extended_set_config_bit, run};
         `MXD_ADDR_STAT: rd_val = {21'h0, st, q_phase, 3'h0, undec, flag_n, flag_z};
         `MXD_ADDR_ACC: rd_val = {24'h0, working_register};
         `MXD_ADDR_PC: rd_val = {11'h0, prog_addr};
         `MXD_ADDR_PTR0: rd_val = {20'h0, file_select_pointer[0]};
         `MXD_ADDR_PTR1: rd_val = {20'h0, file_select_pointer[1]};
         `MXD_ADDR_PTR2: rd_val = {20'h0, file_select_pointer[2]};
         `MXD_ADDR_BANK: rd_val = {11'h0, program_counter_upper_latch,
            program_counter_high_latch, 4'h0, bank_select_register};
         `MXD_ADDR_DBG_ADDR: rd_val = {20'h0, dbg_addr};
         `MXD_ADDR_DBG_DATA: rd_val = {24'h0, dmem[dbg_addr]};
         `MXD_ADDR_STACK: rd_val = {3'h0, 8'(sp), top_of_return_stack};
         default: rd_val = 32'h0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dphase <= '0;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (clk_en) begin
         dphase.wr <= ap_ok && hwrite;
         dphase.addr <= haddr[11:0];
         if (ap_ok && !hwrite) begin
            hrdata <= rd_val;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         run <= 1'b0;
         extended_set_config_bit <= 1'b0;
         bank_select_register <= 4'h0;
         program_counter_high_latch <= 8'h00;
         program_counter_upper_latch <= 5'h00;
         dbg_addr <= 12'h000;
      end else if (clk_en && dphase.wr) begin
         if (dphase.addr == `MXD_ADDR_CTRL) begin
            run <= hwdata[`MXD_CTRL_RUN];
            extended_set_config_bit <= hwdata[`MXD_CTRL_EXT];
         end
         if (dphase.addr == `MXD_ADDR_DBG_ADDR) begin
            dbg_addr <= hwdata[11:0];
         end
         if (!run && (dphase.addr == `MXD_ADDR_BANK)) begin
            bank_select_register <= hwdata[3:0];
            program_counter_high_latch <= hwdata[15:8];
            program_counter_upper_latch <= hwdata[20:16];
         end
      end
   end

   // Sticky flag for an extended opcode met while the set is off; set beats clear.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         undec <= 1'b0;
      end else if (clk_en) begin
         if (retire && (st == MXD_EXEC) && dec.ext_seen && !extended_set_config_bit) begin
            undec <= 1'b1;
         end else if (dphase.wr && (dphase.addr == `MXD_ADDR_STAT) &&
               hwdata[`MXD_STAT_UNDEC]) begin
            undec <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst || !core_step);

   sequence s_retire_exec;
      retire && (st == MXD_EXEC);
   endsequence
   sequence s_skip_two;
      retire && (st == MXD_SKIP) && skip_two;
   endsequence

   xor_lit_a: assert property (s_retire_exec ##0 dec.xor_literal_into_acc |=>
      (working_register == ($past(working_register) ^ $past(ir[7:0]))) &&
      (flag_z == (working_register == 8'h00)) && (flag_n == working_register[7]))
      else $error("xor literal result wrong");
   xor_reg_a: assert property (s_retire_exec ##0 (dec.xor_acc_with_reg && ir[9]) |=>
      (working_register == $past(working_register)) && (flag_z == ($past(res) == 8'h00)))
      else $error("xor register into file wrong");
   skip_zero_a: assert property (s_retire_exec ##0 (dec.test_reg_skip_zero &&
      (opnd == 8'h00)) |=> (st == MXD_SKIP) && (flag_z == $past(flag_z)))
      else $error("skip on zero not taken");
   skip_two_a: assert property (s_skip_two |=> (st == MXD_SKIP2) ##4 (st == MXD_EXEC))
      else $error("two word skip not three cycles");
   flush_quiet_a: assert property (((st == MXD_SKIP) || (st == MXD_SKIP2) ||
      (st == MXD_BUBBLE)) |-> !dm_we ##1 (working_register == $past(working_register)))
      else $error("flush cycle did work");
   ptr_add_a: assert property (s_retire_exec ##0 dec.add_literal_to_pointer |=>
      (file_select_pointer[$past(ir[7:6])] ==
      $past(file_select_pointer[ir[7:6]]) + {6'h00, $past(ir[5:0])}))
      else $error("pointer add wrong");
   ret_add_a: assert property (s_retire_exec ##0 dec.add_stack_ptr_and_return |=>
      (prog_addr == $past(top_of_return_stack)) && (st == MXD_BUBBLE))
      else $error("add and return wrong");
   push_lit_a: assert property (s_retire_exec ##0 dec.push_literal |=>
      (stack_pointer_register == $past(stack_pointer_register) - 12'h001))
      else $error("push literal pointer wrong");
   call_acc_a: assert property (s_retire_exec ##0 dec.call_via_acc |=>
      (prog_addr[7:0] == $past(working_register)) &&
      (top_of_return_stack == $past(prog_addr) + `MXD_PC_STEP))
      else $error("call via accumulator wrong");
   ext_off_a: assert property (s_retire_exec ##0 (dec.ext_seen &&
      !extended_set_config_bit) |=> (prog_addr == $past(prog_addr) + `MXD_PC_STEP) &&
      (stack_pointer_register == $past(stack_pointer_register)) && undec)
      else $error("disabled extended opcode acted");
   ind_zero_a: assert property ((st == MXD_EXEC) && (q_phase == `MXD_Q2) &&
      dec.move_indexed_to_file && is_indirect(src_addr) |=> (opnd == 8'h00))
      else $error("indirect source not zero");

endmodule

// ==== mxd_map.svh ====
`ifndef MXD_MAP_SVH
`define MXD_MAP_SVH

// ****************************************************************
// Register offsets on the bus
// ****************************************************************
`define MXD_ADDR_CTRL 12'h000
`define MXD_ADDR_STAT 12'h004
`define MXD_ADDR_ACC 12'h008
`define MXD_ADDR_PC 12'h00C
`define MXD_ADDR_PTR0 12'h010
`define MXD_ADDR_PTR1 12'h014
`define MXD_ADDR_PTR2 12'h018
`define MXD_ADDR_BANK 12'h01C
`define MXD_ADDR_DBG_ADDR 12'h020
`define MXD_ADDR_DBG_DATA 12'h024
`define MXD_ADDR_STACK 12'h028

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define MXD_CTRL_RUN 0
`define MXD_CTRL_EXT 1
`define MXD_STAT_Z 0
`define MXD_STAT_N 1
`define MXD_STAT_UNDEC 2
`define MXD_CTRL_RESET 2'h0
`define MXD_PC_RESET 21'h000000

// ****************************************************************
// Opcode patterns
// ****************************************************************
`define MXD_OP_TST 7'h33
`define MXD_OP_XOR_LITERAL_INTO_ACC 8'h0A
`define MXD_OP_XOR_ACC_WITH_REG 6'h06
`define MXD_OP_ADDP 8'hE8
`define MXD_OP_SUBP 8'hE9
`define MXD_OP_PUSH_LITERAL 8'hEA
`define MXD_OP_MOVS 8'hEB
`define MXD_OP_CALL_VIA_ACC 16'h0014
`define MXD_OP_MOVFF 4'hC
`define MXD_OP_CALL 7'h76
`define MXD_OP_LDPTR 8'hEE
`define MXD_OP_GOTO 8'hEF
`define MXD_STACK_SEL 2'h3

// ****************************************************************
// Data address space
// ****************************************************************
`define MXD_ILO_MAX 8'h5F
`define MXD_ACC_SPLIT 8'h60
`define MXD_IND_LO 5'h1B
`define MXD_IND_HI 5'h1D
`define MXD_IND_MIN 3'h3
`define MXD_DST_PCLOW 12'hFF9
`define MXD_DST_RSL 12'hFFD
`define MXD_DST_RSH 12'hFFE
`define MXD_DST_RSU 12'hFFF

// ****************************************************************
// Quarter phases and timing
// ****************************************************************
`define MXD_Q1 2'h0
`define MXD_Q2 2'h1
`define MXD_Q3 2'h2
`define MXD_Q4 2'h3
`define MXD_PC_STEP 21'h000002

`endif

// ==== mxd_pkg.sv ====
package mxd_pkg;

   // Gray along exec -> skip -> skip2; bubble and word2 hang off exec.
   typedef enum logic [2:0] {
      MXD_EXEC = 3'h0,
      MXD_SKIP = 3'h1,
      MXD_SKIP2 = 3'h3,
      MXD_BUBBLE = 3'h2,
      MXD_WORD2 = 3'h6
   } mxd_state_t;

   typedef struct packed {
      logic test_reg_skip_zero;
      logic xor_literal_into_acc;
      logic xor_acc_with_reg;
      logic add_literal_to_pointer;
      logic sub_literal_from_pointer;
      logic add_stack_ptr_and_return;
      logic sub_stack_ptr_and_return;
      logic push_literal;
      logic call_via_acc;
      logic move_indexed_to_file;
      logic move_indexed_to_indexed;
      logic ext_seen;
   } mxd_dec_t;

   typedef struct packed {
      logic wr;
      logic [11:0] addr;
   } mxd_bus_t;

endpackage

// ==== mxd_prog_mem.sv ====
`timescale 1ns/1ps
// ***
// Program memory seen by the core
// ***
module mxd_prog_mem (
   input wire logic [20:0] prog_addr,
   output logic [15:0] instr_word
);
   logic [15:0] mem [0:63];
   // Empty words read zero, which the core runs as a one-cycle no-op.
   initial begin
      for (int i = 0; i < 64; i++) begin
         mem[i] = 16'h0000;
      end
      mem[0] = 16'h0AAF;
      mem[1] = 16'h6610;
      mem[2] = 16'h0AFF;
      mem[3] = 16'h6611;
      mem[4] = 16'h0A01;
      mem[5] = 16'h1A11;
      mem[6] = 16'h1811;
      mem[7] = 16'h0A05;
      // Call, skip over a two-word word, indexed moves and both returns.
      mem[12] = 16'h0014;
      mem[13] = 16'h0014;
      mem[22] = 16'h6740;
      mem[23] = 16'hC000;
      mem[24] = 16'h0AFF;
      mem[25] = 16'h1A01;
      mem[26] = 16'hEB81;
      mem[27] = 16'hF002;
      mem[28] = 16'hEB5B;
      mem[29] = 16'hFF81;
      mem[30] = 16'hE8C5;
      mem[31] = 16'hE9C3;
      mem[33] = 16'hEA42;
      mem[34] = 16'hE823;
      mem[35] = 16'hE905;
      mem[49] = 16'hEA42;
   end
   assign instr_word = mem[prog_addr[6:1]];
endmodule
